// *** src/rcg_pkg.sv ***
package rcg_pkg;

    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_RING_OFFSET = 10'h013;
    localparam logic [9:0] IDX_RING_FREQ = 10'h014;
    localparam logic [9:0] IDX_RING_AMP = 10'h015;
    localparam logic [9:0] IDX_RING_PHASE = 10'h016;
    localparam logic [9:0] IDX_RING_HEADROOM = 10'h028;
    localparam logic [9:0] IDX_RING_CTRL = 10'h022;
    localparam logic [9:0] IDX_ACT_TIMER = 10'h030;
    localparam logic [9:0] IDX_INACT_TIMER = 10'h032;
    localparam logic [9:0] IDX_LINEFEED = 10'h040;
    localparam logic [9:0] IDX_HIGH_BATTERY = 10'h04A;
    localparam logic [9:0] IDX_BOOST = 10'h06C;

    // Field positions and widths
    localparam int CTRL_SHAPE_BIT = 0;
    localparam int CTRL_OFFSET_BIT = 1;
    localparam int CTRL_ACT_EN_BIT = 3;
    localparam int CTRL_INACT_EN_BIT = 4;
    localparam int BOOST_EN_BIT = 7;
    localparam int LF_W = 3;
    localparam int VBAT_W = 6;
    localparam int HEAD_W = 4;

    // Linefeed codes
    localparam logic [2:0] LF_OPEN = 3'h0;
    localparam logic [2:0] LF_ONHOOK_TX = 3'h2;
    localparam logic [2:0] LF_RINGING = 3'h4;

    // Reset values
    localparam logic [15:0] RST_WORD = 16'h0000;

    // Timing
    localparam int CLK_HZ = 250000000;
    localparam int SAMPLE_RATE_HZ = 8000;
    localparam int SAMPLE_DIV = CLK_HZ / SAMPLE_RATE_HZ;
    localparam int DIV_W = 15;
    localparam logic [4:0] BOOST_SAMPLES = 5'h10;

    // Cadence states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RING_ON = 2'b01,
        ST_RING_OFF = 2'b10
    } rcg_cad_e;

    // Ringing control bits
    typedef struct packed {
        logic inact_en;
        logic act_en;
        logic offset_en;
        logic trap_sel;
    } rcg_cfg_s;

    localparam rcg_cfg_s RST_CFG = 4'h0;

endpackage

// *** src/rcg_ringing_gen.sv ***
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Writing the ringing linefeed code enters ringing and starts a burst.
// - Active timer expiry stops the waveform, line goes on-hook transmission.
// - Inactive timer expiry restarts ringing while timers enabled and ringing selected.
// - Sine mode uses a recursive oscillator set by coefficient, amplitude, phase.
// - Shape select bit 0 of control: 0 sine, 1 trapezoid.
// - Trapezoid adds or subtracts the coefficient each sample, clipped at amplitude.
// - Trapezoid phase/period value is the half-period in samples; ramp reverses.
// - Offset enable bit 1 of control adds the offset value to the waveform.
// - Common-mode level is high battery minus headroom, held at zero when headroom is not below it.
// - Headroom is a 4-bit field, 1.5 V per step, at index 40.
// - Boost enable bit 7 at index 108 raises current limit leaving ringing.
module rcg_ringing_gen #(
    parameter int SAMPLE_DIV = rcg_pkg::SAMPLE_DIV
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Line drive
    output logic signed [15:0] ring_wave,
    output logic ring_active,
    output logic [2:0] line_state,
    output logic [5:0] ring_common_mode_level,
    output logic current_boost
);

    ////////////////////////////////////////////////////////////////////////
    // Register file over APB
    logic [15:0] offset_ff, nxt_offset, freq_ff, nxt_freq;
    logic [15:0] amp_ff, nxt_amp, phase_ff, nxt_phase;
    logic [15:0] act_tmr_ff, nxt_act_tmr, inact_tmr_ff, nxt_inact_tmr;
    logic [3:0] headroom_ff, nxt_headroom;
    logic [5:0] high_battery_setting_ff, nxt_high_battery_setting;
    logic boost_en_ff, nxt_boost_en;
    rcg_pkg::rcg_cfg_s cfg_ff, nxt_cfg;
    logic [31:0] prdata_ff, nxt_prdata;
    logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
    logic [2:0] line_state_ff, nxt_line_state;
    logic [9:0] idx;
    logic setup, wr_en, hit, lf_wr, lf_ring_wr;
    logic [31:0] rd_word;

    assign idx = paddr[11:2];
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready_ff && pwrite;
    assign lf_wr = wr_en && (idx == rcg_pkg::IDX_LINEFEED);
    assign lf_ring_wr = lf_wr && (pwdata[2:0] == rcg_pkg::LF_RINGING);

    // Read mux and decode
    always_comb begin
        hit = 1'b1;
        rd_word = 32'h00000000;
        case (idx)
            rcg_pkg::IDX_RING_OFFSET: rd_word = {16'h0000, offset_ff};
            rcg_pkg::IDX_RING_FREQ: rd_word = {16'h0000, freq_ff};
            rcg_pkg::IDX_RING_AMP: rd_word = {16'h0000, amp_ff};
            rcg_pkg::IDX_RING_PHASE: rd_word = {16'h0000, phase_ff};
            rcg_pkg::IDX_RING_HEADROOM: rd_word = {28'h0000000, headroom_ff};
            rcg_pkg::IDX_RING_CTRL: rd_word = {27'h0000000, cfg_ff[3:2],
                                              1'b0, cfg_ff[1:0]};
            rcg_pkg::IDX_ACT_TIMER: rd_word = {16'h0000, act_tmr_ff};
            rcg_pkg::IDX_INACT_TIMER: rd_word = {16'h0000, inact_tmr_ff};
            rcg_pkg::IDX_LINEFEED: rd_word = {29'h0000000, line_state_ff};
            rcg_pkg::IDX_HIGH_BATTERY: rd_word = {26'h0000000, high_battery_setting_ff};
            rcg_pkg::IDX_BOOST: rd_word = {24'h000000, boost_en_ff, 7'h00};
            default: hit = 1'b0;
        endcase
    end

    // Next register values; no wait states, pready follows the setup phase
    always_comb begin
        nxt_offset = offset_ff;
        nxt_freq = freq_ff;
        nxt_amp = amp_ff;
        nxt_phase = phase_ff;
        nxt_headroom = headroom_ff;
        nxt_cfg = cfg_ff;
        nxt_act_tmr = act_tmr_ff;
        nxt_inact_tmr = inact_tmr_ff;
        nxt_high_battery_setting = high_battery_setting_ff;
        nxt_boost_en = boost_en_ff;
        nxt_pready = setup;
        nxt_pslverr = setup && !hit;
        nxt_prdata = (setup && !pwrite && hit) ? rd_word : 32'h00000000;
        if (wr_en) begin
            case (idx)
                rcg_pkg::IDX_RING_OFFSET: nxt_offset = pwdata[15:0];
                rcg_pkg::IDX_RING_FREQ: nxt_freq = pwdata[15:0];
                rcg_pkg::IDX_RING_AMP: nxt_amp = pwdata[15:0];
                rcg_pkg::IDX_RING_PHASE: nxt_phase = pwdata[15:0];
                rcg_pkg::IDX_RING_HEADROOM: nxt_headroom = pwdata[3:0];
                rcg_pkg::IDX_RING_CTRL: begin
                    nxt_cfg.trap_sel = pwdata[rcg_pkg::CTRL_SHAPE_BIT];
                    nxt_cfg.offset_en = pwdata[rcg_pkg::CTRL_OFFSET_BIT];
                    nxt_cfg.act_en = pwdata[rcg_pkg::CTRL_ACT_EN_BIT];
                    nxt_cfg.inact_en = pwdata[rcg_pkg::CTRL_INACT_EN_BIT];
                end
                rcg_pkg::IDX_ACT_TIMER: nxt_act_tmr = pwdata[15:0];
                rcg_pkg::IDX_INACT_TIMER: nxt_inact_tmr = pwdata[15:0];
                rcg_pkg::IDX_HIGH_BATTERY: nxt_high_battery_setting = pwdata[5:0];
                rcg_pkg::IDX_BOOST: nxt_boost_en = pwdata[rcg_pkg::BOOST_EN_BIT];
                default: nxt_boost_en = boost_en_ff;
            endcase
        end
    end

    // Register storage
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            offset_ff <= rcg_pkg::RST_WORD;
            freq_ff <= rcg_pkg::RST_WORD;
            amp_ff <= rcg_pkg::RST_WORD;
            phase_ff <= rcg_pkg::RST_WORD;
            headroom_ff <= 4'h0;
            cfg_ff <= rcg_pkg::RST_CFG;
            act_tmr_ff <= rcg_pkg::RST_WORD;
            inact_tmr_ff <= rcg_pkg::RST_WORD;
            high_battery_setting_ff <= 6'h00;
            boost_en_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            offset_ff <= nxt_offset;
            freq_ff <= nxt_freq;
            amp_ff <= nxt_amp;
            phase_ff <= nxt_phase;
            headroom_ff <= nxt_headroom;
            cfg_ff <= nxt_cfg;
            act_tmr_ff <= nxt_act_tmr;
            inact_tmr_ff <= nxt_inact_tmr;
            high_battery_setting_ff <= nxt_high_battery_setting;
            boost_en_ff <= nxt_boost_en;
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sample tick and cadence
    logic [rcg_pkg::DIV_W-1:0] div_ff, nxt_div;
    logic tick_ff, nxt_tick;
    rcg_pkg::rcg_cad_e state_ff, nxt_state;
    logic [15:0] tmr_ff, nxt_tmr;
    logic [4:0] boost_cnt_ff, nxt_boost_cnt;
    logic gen_start, expired;

    assign expired = tick_ff && (tmr_ff <= 16'h0001);

    // Sample rate divider
    always_comb begin
        nxt_tick = (div_ff == rcg_pkg::DIV_W'(SAMPLE_DIV - 1));
        nxt_div = nxt_tick ? '0 : div_ff + 1'b1;
    end

    // Cadence next state
    always_comb begin
        nxt_state = state_ff;
        nxt_tmr = tick_ff ? tmr_ff - 16'h0001 : tmr_ff;
        nxt_line_state = line_state_ff;
        gen_start = 1'b0;
        case (state_ff)
            rcg_pkg::ST_IDLE: nxt_state = rcg_pkg::ST_IDLE;
            rcg_pkg::ST_RING_ON: begin
                if (cfg_ff.act_en && expired) begin
                    nxt_state = rcg_pkg::ST_RING_OFF;
                    nxt_line_state = rcg_pkg::LF_ONHOOK_TX;
                    nxt_tmr = inact_tmr_ff;
                end
            end
            rcg_pkg::ST_RING_OFF: begin
                if (cfg_ff.act_en && cfg_ff.inact_en && expired) begin
                    nxt_state = rcg_pkg::ST_RING_ON;
                    nxt_line_state = rcg_pkg::LF_RINGING;
                    nxt_tmr = act_tmr_ff;
                    gen_start = 1'b1;
                end
            end
            default: nxt_state = rcg_pkg::ST_IDLE;
        endcase
        if (lf_ring_wr) begin
            nxt_state = rcg_pkg::ST_RING_ON;
            nxt_line_state = rcg_pkg::LF_RINGING;
            nxt_tmr = act_tmr_ff;
            gen_start = 1'b1;
        end else if (lf_wr) begin
            nxt_state = rcg_pkg::ST_IDLE;
            nxt_line_state = pwdata[2:0];
        end
    end

    // Boost window after leaving the ringing burst
    always_comb begin
        nxt_boost_cnt = (boost_cnt_ff != 5'h00 && tick_ff)
                      ? boost_cnt_ff - 5'h01 : boost_cnt_ff;
        if (state_ff == rcg_pkg::ST_RING_ON &&
            nxt_state != rcg_pkg::ST_RING_ON && boost_en_ff) begin
            nxt_boost_cnt = rcg_pkg::BOOST_SAMPLES;
        end
    end

    // Cadence registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            div_ff <= '0;
            tick_ff <= 1'b0;
            state_ff <= rcg_pkg::ST_IDLE;
            tmr_ff <= 16'h0000;
            line_state_ff <= rcg_pkg::LF_OPEN;
            boost_cnt_ff <= 5'h00;
        end else begin
            div_ff <= nxt_div;
            tick_ff <= nxt_tick;
            state_ff <= nxt_state;
            tmr_ff <= nxt_tmr;
            line_state_ff <= nxt_line_state;
            boost_cnt_ff <= nxt_boost_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Waveform and common mode
    logic signed [15:0] sine_wave, trap_wave, sel_wave;
    logic signed [16:0] sum_wave;
    logic signed [15:0] wave_ff, nxt_wave;
    logic [5:0] cm_ff, nxt_cm;
    logic active_ff, nxt_active, boost_ff, nxt_boost;

    rcg_sine_osc u_sine (
        .clk(clk),
        .resetn(resetn),
        .start(gen_start),
        .tick(tick_ff),
        .coeff(freq_ff),
        .amp(amp_ff),
        .phase(phase_ff),
        .wave(sine_wave)
    );

    rcg_trap_gen u_trap (
        .clk(clk),
        .resetn(resetn),
        .start(gen_start),
        .tick(tick_ff),
        .step(freq_ff),
        .amp(amp_ff),
        .half_period(phase_ff),
        .wave(trap_wave)
    );

    // Shape select, offset, clip; silent outside the burst
    always_comb begin
        sel_wave = cfg_ff.trap_sel ? trap_wave : sine_wave;
        sum_wave = cfg_ff.offset_en
                 ? 17'(sel_wave) + 17'($signed(offset_ff))
                 : 17'(sel_wave);
        if (sum_wave > 17'sh07FFF) begin
            nxt_wave = 16'sh7FFF;
        end else if (sum_wave < -17'sh08000) begin
            nxt_wave = -16'sh8000;
        end else begin
            nxt_wave = 16'(sum_wave);
        end
        if (state_ff != rcg_pkg::ST_RING_ON) begin
            nxt_wave = 16'sh0000;
        end
        nxt_cm = (high_battery_setting_ff > {2'b00, headroom_ff})
               ? high_battery_setting_ff - {2'b00, headroom_ff} : 6'h00;
        nxt_active = (nxt_state == rcg_pkg::ST_RING_ON);
        nxt_boost = (nxt_boost_cnt != 5'h00);
    end

    // Output registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wave_ff <= 16'sh0000;
            cm_ff <= 6'h00;
            active_ff <= 1'b0;
            boost_ff <= 1'b0;
        end else begin
            wave_ff <= nxt_wave;
            cm_ff <= nxt_cm;
            active_ff <= nxt_active;
            boost_ff <= nxt_boost;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign ring_wave = wave_ff;
    assign ring_active = active_ff;
    assign line_state = line_state_ff;
    assign ring_common_mode_level = cm_ff;
    assign current_boost = boost_ff;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    sequence s_off_expiry;
        state_ff == rcg_pkg::ST_RING_OFF && cfg_ff.act_en &&
        cfg_ff.inact_en && expired && !lf_wr;
    endsequence

    property p_ring_start;
        @(posedge clk) disable iff (!resetn)
        lf_ring_wr |=> state_ff == rcg_pkg::ST_RING_ON && ring_active &&
                       line_state == rcg_pkg::LF_RINGING;
    endproperty
    a_ring_start: assert property (p_ring_start) else $error("no ring start");

    property p_active_expiry;
        @(posedge clk) disable iff (!resetn)
        (state_ff == rcg_pkg::ST_RING_ON && cfg_ff.act_en && expired && !lf_wr)
        |=> state_ff == rcg_pkg::ST_RING_OFF &&
            line_state == rcg_pkg::LF_ONHOOK_TX ##1 ring_wave == 16'sh0000;
    endproperty
    a_active_expiry: assert property (p_active_expiry) else $error("burst not ended");

    property p_inactive_expiry;
        @(posedge clk) disable iff (!resetn)
        s_off_expiry |=> state_ff == rcg_pkg::ST_RING_ON && tmr_ff == act_tmr_ff;
    endproperty
    a_inactive_expiry: assert property (p_inactive_expiry) else $error("no restart");

    property p_shape;
        @(posedge clk) disable iff (!resetn)
        (state_ff == rcg_pkg::ST_RING_ON && !cfg_ff.offset_en)
        |=> ring_wave == ($past(cfg_ff.trap_sel) ? $past(trap_wave)
                                                  : $past(sine_wave));
    endproperty
    a_shape: assert property (p_shape) else $error("wrong shape");

    property p_quiet_off;
        @(posedge clk) disable iff (!resetn)
        state_ff == rcg_pkg::ST_RING_OFF [*2] |-> ring_wave == 16'sh0000 && !ring_active;
    endproperty
    a_quiet_off: assert property (p_quiet_off) else $error("wave in pause");

    property p_common_mode;
        @(posedge clk) disable iff (!resetn)
        (high_battery_setting_ff > {2'b00, headroom_ff}) |=>
        ring_common_mode_level == $past(high_battery_setting_ff) - {2'b00, $past(headroom_ff)};
    endproperty
    a_common_mode: assert property (p_common_mode) else $error("bad common mode");

    property p_boost;
        @(posedge clk) disable iff (!resetn)
        (state_ff == rcg_pkg::ST_RING_ON && nxt_state != rcg_pkg::ST_RING_ON &&
         boost_en_ff) |=> current_boost [*8];
    endproperty
    a_boost: assert property (p_boost) else $error("no boost");

    property p_stop;
        @(posedge clk) disable iff (!resetn)
        (lf_wr && !lf_ring_wr) |=> state_ff == rcg_pkg::ST_IDLE ##1
        ring_wave == 16'sh0000;
    endproperty
    a_stop: assert property (p_stop) else $error("ringing not stopped");

    property p_tick_spacing;
        @(posedge clk) disable iff (!resetn)
        tick_ff |=> !tick_ff [*2];
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) else $error("tick too fast");

endmodule // rcg_ringing_gen

`default_nettype wire

// *** src/rcg_sine_osc.sv ***
`timescale 1ns/1ps
`default_nettype none

module rcg_sine_osc (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Control
    input wire logic start,
    input wire logic tick,
    // Settings
    input wire logic [15:0] coeff,
    input wire logic [15:0] amp,
    input wire logic [15:0] phase,
    // Sample out
    output logic signed [15:0] wave
);

    logic signed [17:0] y1_ff, y2_ff, nxt_y1, nxt_y2;
    logic signed [35:0] prod;

    // Two-tap recursion, coefficient in Q15 of the cosine
    always_comb begin
        prod = $signed({2'b00, coeff}) * y1_ff;
        nxt_y1 = y1_ff;
        nxt_y2 = y2_ff;
        if (start) begin
            nxt_y1 = 18'($signed(phase));
            nxt_y2 = -18'($signed(amp));
        end else if (tick) begin
            nxt_y1 = 18'(prod >>> 14) - y2_ff;
            nxt_y2 = y1_ff;
        end
    end

    // State registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            y1_ff <= 18'h00000;
            y2_ff <= 18'h00000;
        end else begin
            y1_ff <= nxt_y1;
            y2_ff <= nxt_y2;
        end
    end

    // Gain of four, clipped to 16 bits
    always_comb begin
        if (y1_ff > 18'sh01FFF) begin
            wave = 16'sh7FFF;
        end else if (y1_ff < -18'sh02000) begin
            wave = -16'sh8000;
        end else begin
            wave = 16'(y1_ff <<< 2);
        end
    end

endmodule // rcg_sine_osc

`default_nettype wire

// *** src/rcg_trap_gen.sv ***
`timescale 1ns/1ps
`default_nettype none

module rcg_trap_gen (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Control
    input wire logic start,
    input wire logic tick,
    // Settings
    input wire logic [15:0] step,
    input wire logic [15:0] amp,
    input wire logic [15:0] half_period,
    // Sample out
    output logic signed [15:0] wave
);

    logic signed [17:0] v_ff, nxt_v, lim, sum;
    logic up_ff, nxt_up;
    logic [15:0] cnt_ff, nxt_cnt;

    // Ramp by the step each sample, clip at the amplitude
    always_comb begin
        lim = $signed({2'b00, amp});
        sum = up_ff ? v_ff + $signed({2'b00, step})
                    : v_ff - $signed({2'b00, step});
        nxt_v = v_ff;
        nxt_up = up_ff;
        nxt_cnt = cnt_ff;
        if (start) begin
            nxt_v = 18'sh00000;
            nxt_up = 1'b1;
            nxt_cnt = 16'h0000;
        end else if (tick) begin
            if (sum > lim) begin
                nxt_v = lim;
            end else if (sum < -lim) begin
                nxt_v = -lim;
            end else begin
                nxt_v = sum;
            end
            if (cnt_ff + 16'h0001 >= half_period) begin
                nxt_up = ~up_ff;
                nxt_cnt = 16'h0000;
            end else begin
                nxt_cnt = cnt_ff + 16'h0001;
            end
        end
    end

    // State registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            v_ff <= 18'sh00000;
            up_ff <= 1'b1;
            cnt_ff <= 16'h0000;
        end else begin
            v_ff <= nxt_v;
            up_ff <= nxt_up;
            cnt_ff <= nxt_cnt;
        end
    end

    assign wave = 16'(v_ff);

endmodule // rcg_trap_gen

`default_nettype wire

// *** testbench/ringing_cadence_waveform_gen_test.sv ***
`timescale 1ns/1ps
`default_nettype none

module ringing_cadence_waveform_gen_test;
    logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, ring_active, current_boost, er;
    logic signed [15:0] ring_wave;
    logic [2:0] line_state;
    logic [5:0] cm;
    int failures = 0, checks_done = 0, cyc = 0, n, y, y1, y2, hb, hd;
    int unsigned xs = 8;
    int q[$], m[$];
    logic [9:0] ix [5] = '{rcg_pkg::IDX_RING_OFFSET, rcg_pkg::IDX_RING_FREQ,
        rcg_pkg::IDX_RING_AMP, rcg_pkg::IDX_RING_PHASE,
        rcg_pkg::IDX_RING_HEADROOM};

    // Device with a short sample period
    rcg_ringing_gen #(.SAMPLE_DIV(8)) dut_u (.clk(clk), .resetn(resetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ring_wave(ring_wave),
        .ring_active(ring_active), .line_state(line_state),
        .ring_common_mode_level(cm), .current_boost(current_boost));

    ////////////////////////////////////////////////////////////
    // Clock and hang guard
    always #2 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc > 30000) begin
            failures++;
            report_and_stop();
        end
    end

    // Read data and error taken at the completing edge
    always @(posedge clk) begin
        if (psel && penable && pready) begin
            rd <= prdata;
            er <= pslverr;
        end
    end

    // Xorshift source
    function automatic logic [31:0] rnd();
        xs ^= xs << 13;
        xs ^= xs >> 17;
        xs ^= xs << 5;
        return xs;
    endfunction

    // Compare and count
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            failures++;
            $display("ERROR at %0t: saw %h, expected %h", $time, s, e);
        end
    endtask

    // Verdict and end of run
    task automatic report_and_stop();
        $display("checks %0d, failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [9:0] i,
                       input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        #1;
        while (pready !== 1'b1 && t < 20) begin
            @(posedge clk);
            #1;
            t++;
        end
        @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
        if (t >= 20)
            failures++;
    endtask

    // Wait for a level under a bound
    task automatic wt(ref logic s, input logic v);
        n = 0;
        while (s !== v && n < 1000) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(s, v);
    endtask

    // Collect successive changes of the wave
    task automatic cap(input int k);
        logic signed [15:0] p;
        int t;
        p = ring_wave;
        t = 0;
        q.delete();
        while (q.size() < k && t < 3000) begin
            @(posedge clk);
            #1;
            t++;
            if (ring_wave !== p)
                q.push_back(int'(ring_wave));
            p = ring_wave;
        end
        check(q.size(), k);
    endtask

    ////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        apb(0, rcg_pkg::IDX_LINEFEED, 0);
        check(rd, 0);
        apb(1, 10'h3FF, 32'hFFFFFFFF);
        check(er, 1);
        apb(0, 10'h3FF, 0);
        check(rd, 0);
        for (int i = 0; i < 5; i++) begin
            y = rnd();
            apb(1, ix[i], y);
            apb(0, ix[i], 0);
            check(rd, y & (i < 4 ? 32'hFFFF : 32'hF));
        end
        // Common-mode level, saturating case first
        for (int i = 0; i < 4; i++) begin
            hb = (i == 0) ? 2 : rnd() % 64;
            hd = (i == 0) ? 9 : rnd() % 16;
            apb(1, rcg_pkg::IDX_HIGH_BATTERY, hb);
            apb(1, rcg_pkg::IDX_RING_HEADROOM, hd);
            repeat (3) @(posedge clk);
            #1;
            check(cm, hb > hd ? hb - hd : 0);
        end
        // Sine burst against the recursion model
        apb(1, rcg_pkg::IDX_RING_FREQ, 32'h7EFD);
        apb(1, rcg_pkg::IDX_RING_AMP, 32'h177);
        apb(1, rcg_pkg::IDX_HIGH_BATTERY, 32'h3F);
        apb(1, rcg_pkg::IDX_RING_HEADROOM, 5);
        apb(1, rcg_pkg::IDX_RING_PHASE, 0);
        apb(1, rcg_pkg::IDX_RING_CTRL, 0);
        y1 = 0;
        y2 = -375;
        for (int i = 0; i < 5; i++) begin
            y = ((32'sh7EFD * y1) >>> 14) - y2;
            y2 = y1;
            y1 = y;
            m.push_back(4 * y1);
        end
        apb(1, rcg_pkg::IDX_LINEFEED, 4);
        @(posedge clk);
        #1;
        check(ring_active, 1);
        check(line_state, 4);
        check(cm, 32'h3A);
        cap(5);
        foreach (m[i]) check(q[i], m[i]);
        // Stop, then trapezoid with offset
        apb(1, rcg_pkg::IDX_LINEFEED, 0);
        @(posedge clk);
        #1;
        check(ring_active, 0);
        check(ring_wave, 0);
        check(current_boost, 0);
        apb(1, rcg_pkg::IDX_RING_OFFSET, 32'h10);
        apb(1, rcg_pkg::IDX_RING_FREQ, 32'h100);
        apb(1, rcg_pkg::IDX_RING_AMP, 32'h300);
        apb(1, rcg_pkg::IDX_RING_PHASE, 6);
        apb(1, rcg_pkg::IDX_RING_CTRL, 3);
        apb(1, rcg_pkg::IDX_LINEFEED, 4);
        cap(16);
        hb = q[0];
        hd = q[0];
        for (int i = 1; i < 16; i++) begin
            check((q[i] - q[i-1]) inside {256, -256}, 1);
            hb = q[i] > hb ? q[i] : hb;
            hd = q[i] < hd ? q[i] : hd;
        end
        check(hb, 32'h310);
        check(hd, -32'sh2F0);
        // Cadence of bursts and pauses
        apb(1, rcg_pkg::IDX_LINEFEED, 0);
        apb(1, rcg_pkg::IDX_ACT_TIMER, 3);
        apb(1, rcg_pkg::IDX_INACT_TIMER, 2);
        apb(1, rcg_pkg::IDX_RING_CTRL, 32'h18);
        apb(1, rcg_pkg::IDX_LINEFEED, 4);
        repeat (2) begin
            wt(ring_active, 0);
            check(n inside {[16:28]}, 1);
            check(line_state, 2);
            wt(ring_active, 1);
            check(line_state, 4);
        end
        // Boost window on leaving the burst
        apb(1, rcg_pkg::IDX_BOOST, 32'h80);
        apb(1, rcg_pkg::IDX_LINEFEED, 0);
        wt(current_boost, 1);
        check(line_state, 0);
        wt(current_boost, 0);
        check(n inside {[112:136]}, 1);
        report_and_stop();
    end
endmodule // ringing_cadence_waveform_gen_test

`default_nettype wire
